//--- eda_pkg.sv
// Operation
// RL1: 16-bit move addresses from data pointer
// RL2: 8-bit move uses page plus index
// RL3: page register resets zero, selects 256-byte page
// RL4: port group bit picks lower/upper pins
// RL5: software sets crossbar skip on lower group
// RL6: pins claimed only during off-chip move
// RL7: input pins have drivers disabled
// RL8: pin output mode left to port logic
// RL9: software parks pins push-pull at one
// RL10: mux bit zero multiplexed, one separate
// RL11: mode 00 all on-chip, aliased
// RL12: mode 01 splits, upper byte from latches
// RL13: mode 01 software sets off-chip page
// RL14: mode 10 splits, upper byte from page
// RL15: mode 11 all off-chip
// RL16: latch strobe high/low widths 1 to 4
// RL17: mux mode shares low address and data
// RL18: strobe high with low address first
// RL19: data owns shared pins during strobe
// RL20: config bits 7:6 read zero
// RL21: software configures in documented order
// RL22: on-chip addresses wrap on 4k
// RL23: 8-bit no-bank moves leave upper undriven
// RL24: off-chip move takes programmed plus four
// RL25: on-chip accesses leave pins untouched
package eda_pkg;
  // printed offsets are register indices; byte address is four times
  localparam logic [7:0]  IDX_PAGE  = 8'hA2;
  localparam logic [7:0]  IDX_CFG   = 8'hA3;
  localparam logic [7:0]  IDX_DATA_POINTER  = 8'hB0;
  localparam logic [7:0]  IDX_DPL   = 8'hB1;
  localparam logic [7:0]  IDX_DPH   = 8'hB2;
  localparam logic [7:0]  IDX_INDEX = 8'hB3;
  localparam logic [7:0]  IDX_TMG   = 8'hB4;
  localparam logic [7:0]  IDX_CMD   = 8'hB5;
  localparam logic [7:0]  IDX_STAT  = 8'hB6;
  localparam logic [7:0]  PAGE_RST  = 8'h00;
  localparam logic [5:0]  CFG_RST   = 6'h03;
  localparam logic [7:0]  TMG_RST   = 8'hFF;
  localparam int          CFG_PORT  = 5;
  localparam int          CFG_MUX   = 4;
  localparam int          CFG_MODE  = 2;
  localparam int          CFG_ALE   = 0;
  localparam int          TMG_SETUP = 6;
  localparam int          TMG_STRB  = 2;
  localparam int          TMG_HOLD  = 0;
  localparam int          CMD_DIR   = 0;
  localparam int          CMD_WIDE  = 1;
  localparam int          CMD_IDX   = 2;
  localparam int          CMD_WD    = 8;
  localparam logic [1:0]  MODE_INT  = 2'h0;
  localparam logic [1:0]  MODE_SPL  = 2'h1;
  localparam logic [1:0]  MODE_BNK  = 2'h2;
  localparam logic [1:0]  MODE_EXT  = 2'h3;
  localparam logic [15:0] ONCHIP_TOP = 16'h1000;
  localparam int          RAM_AW    = 12;
  localparam logic [5:0]  FIXED_CYC = 6'h04;
  localparam logic [3:0]  FIN_LD    = 4'h2;
  typedef struct packed {
    logic [7:0] ah;
    logic       ah_oe;
    logic [7:0] al;
    logic       al_oe;
    logic [7:0] d;
    logic       d_oe;
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic       ctl_oe;
  } eda_pins_s;
  localparam eda_pins_s PINS_IDLE = '{8'h00, 1'b0, 8'h00, 1'b0, 8'h00,
                                      1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
endpackage

//--- eda_addr_res.sv
`timescale 1ns/1ps
module eda_addr_res (
  input  wire logic [1:0]  mode,
  input  wire logic        wide,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  page,
  input  wire logic [7:0]  idx,
  output logic      [15:0] ea,
  output logic             offchip,
  output logic             drive_hi
);
  always_comb begin
    ea = wide ? data_pointer : {page, idx}; // RL1 RL2 RL3
    case (mode)
      eda_pkg::MODE_INT: offchip = 1'b0; // RL11
      eda_pkg::MODE_EXT: offchip = 1'b1; // RL15
      default:           offchip = (ea >= eda_pkg::ONCHIP_TOP); // RL12 RL14
    endcase
    // 16-bit moves and bank select drive the upper byte; 8-bit moves in other modes leave the latches
    drive_hi = wide | (mode == eda_pkg::MODE_BNK); // RL12 RL14 RL23
  end
endmodule

//--- eda_tmr.sv
`timescale 1ns/1ps
module eda_tmr #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] val,
  output logic              zero
);
  logic [W-1:0] cnt_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  assign zero = (cnt_r == '0);
endmodule

//--- eda_ctrl.sv
`timescale 1ns/1ps
module eda_ctrl (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   ram_en,
  output logic                   ram_we,
  output logic [11:0]            ram_addr,
  output logic [7:0]             ram_wdata,
  input  wire logic [7:0]        ram_rdata,
  input  wire logic [7:0]        lo_data_i,
  input  wire logic [7:0]        hi_data_i,
  output eda_pkg::eda_pins_s     lo_pins,
  output eda_pkg::eda_pins_s     hi_pins
);
  typedef enum logic [3:0] {
    S_IDLE, S_RAM, S_RAMRD, S_START, S_ALEH, S_ALEL,
    S_SETUP, S_STRB, S_HOLD, S_FIN
  } eda_state_e;

  eda_state_e         state_r;
  eda_state_e         state_nxt;
  logic [7:0]         page_r;
  logic [5:0]         cfg_r;
  logic [15:0]        data_pointer_r;
  logic [7:0]         idx0_r;
  logic [7:0]         idx1_r;
  logic [7:0]         tmg_r;
  logic [31:0]        prdata_r;
  logic               pready_r;
  logic               pslverr_r;
  logic [7:0]         rdat_r;
  logic               last_off_r;
  logic [15:0]        ea_r;
  logic               drive_hi_r;
  logic               dir_r;
  logic [7:0]         wdat_r;
  logic               grp_r;
  logic               mux_r;
  logic [1:0]         alew_r;
  logic [1:0]         setup_r;
  logic [3:0]         strb_r;
  logic [1:0]         hold_r;
  logic               ram_en_r;
  logic               ram_we_r;
  logic [11:0]        ram_addr_r;
  logic [7:0]         ram_wdata_r;
  eda_pkg::eda_pins_s lo_pins_r;
  eda_pkg::eda_pins_s hi_pins_r;
  eda_pkg::eda_pins_s pins_c;
  logic [7:0]         lo_s1_r;
  logic [7:0]         lo_s2_r;
  logic [7:0]         hi_s1_r;
  logic [7:0]         hi_s2_r;
  logic [1:0]         samp_r;
  logic               acc;
  logic               wr;
  logic               hit;
  logic [31:0]        rd_val;
  logic [7:0]         idx_sel;
  logic               go;
  logic [15:0]        ea;
  logic               offchip;
  logic               drive_hi;
  logic               ld;
  logic [3:0]         ld_val;
  logic               zero;
  logic [7:0]         din;

  // registered answer: one wait state, so read data and pready are flops
  assign acc = psel & penable & ~pready_r;
  assign wr  = psel & penable & pready_r & pwrite;
  assign go  = wr & (paddr == {2'h0, eda_pkg::IDX_CMD, 2'h0})
             & (state_r == S_IDLE);

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      {2'h0, eda_pkg::IDX_PAGE, 2'h0}:  rd_val = {24'h0, page_r};
      {2'h0, eda_pkg::IDX_CFG, 2'h0}:   rd_val = {26'h0, cfg_r}; // RL20
      {2'h0, eda_pkg::IDX_DATA_POINTER, 2'h0}:  rd_val = {16'h0, data_pointer_r};
      {2'h0, eda_pkg::IDX_DPL, 2'h0}:   rd_val = {24'h0, data_pointer_r[7:0]};
      {2'h0, eda_pkg::IDX_DPH, 2'h0}:   rd_val = {24'h0, data_pointer_r[15:8]};
      {2'h0, eda_pkg::IDX_INDEX, 2'h0}: rd_val = {16'h0, idx1_r, idx0_r};
      {2'h0, eda_pkg::IDX_TMG, 2'h0}:   rd_val = {24'h0, tmg_r};
      {2'h0, eda_pkg::IDX_CMD, 2'h0}:   rd_val = 32'h0000_0000;
      {2'h0, eda_pkg::IDX_STAT, 2'h0}:
        rd_val = {16'h0, rdat_r, 6'h00, last_off_r, state_r != S_IDLE};
      default:                          hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc;
      prdata_r  <= (acc & ~pwrite) ? rd_val : 32'h0000_0000;
      pslverr_r <= acc & ~hit;
    end
  end

  // software registers; writes land at the edge that completes the access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_r <= eda_pkg::PAGE_RST; // RL3
      cfg_r  <= eda_pkg::CFG_RST;
      data_pointer_r <= 16'h0000;
      idx0_r <= 8'h00;
      idx1_r <= 8'h00;
      tmg_r  <= eda_pkg::TMG_RST;
    end else if (wr) begin
      case (paddr)
        {2'h0, eda_pkg::IDX_PAGE, 2'h0}:  page_r <= pwdata[7:0];
        {2'h0, eda_pkg::IDX_CFG, 2'h0}:   cfg_r <= pwdata[5:0]; // RL20
        {2'h0, eda_pkg::IDX_DATA_POINTER, 2'h0}:  data_pointer_r <= pwdata[15:0]; // RL1
        {2'h0, eda_pkg::IDX_DPL, 2'h0}:   data_pointer_r[7:0] <= pwdata[7:0];
        {2'h0, eda_pkg::IDX_DPH, 2'h0}:   data_pointer_r[15:8] <= pwdata[7:0];
        {2'h0, eda_pkg::IDX_INDEX, 2'h0}: begin
          idx0_r <= pwdata[7:0];
          idx1_r <= pwdata[15:8];
        end
        {2'h0, eda_pkg::IDX_TMG, 2'h0}:   tmg_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  assign idx_sel = pwdata[eda_pkg::CMD_IDX] ? idx1_r : idx0_r; // RL2

  eda_addr_res u_res (
    .mode     (cfg_r[eda_pkg::CFG_MODE +: 2]),
    .wide     (pwdata[eda_pkg::CMD_WIDE]),
    .data_pointer     (data_pointer_r),
    .page     (page_r),
    .idx      (idx_sel),
    .ea       (ea),
    .offchip  (offchip),
    .drive_hi (drive_hi)
  );

  // freeze the move's settings so reconfiguration mid-move is harmless
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ea_r       <= 16'h0000;
      drive_hi_r <= 1'b0;
      dir_r      <= 1'b0;
      wdat_r     <= 8'h00;
      grp_r      <= 1'b0;
      mux_r      <= 1'b0;
      alew_r     <= 2'h0;
      setup_r    <= 2'h0;
      strb_r     <= 4'h0;
      hold_r     <= 2'h0;
      last_off_r <= 1'b0;
    end else if (go) begin
      ea_r       <= ea;
      drive_hi_r <= drive_hi; // RL23
      dir_r      <= pwdata[eda_pkg::CMD_DIR];
      wdat_r     <= pwdata[eda_pkg::CMD_WD +: 8];
      grp_r      <= cfg_r[eda_pkg::CFG_PORT]; // RL4
      mux_r      <= ~cfg_r[eda_pkg::CFG_MUX]; // RL10
      alew_r     <= cfg_r[eda_pkg::CFG_ALE +: 2]; // RL16
      setup_r    <= tmg_r[eda_pkg::TMG_SETUP +: 2];
      strb_r     <= tmg_r[eda_pkg::TMG_STRB +: 4];
      hold_r     <= tmg_r[eda_pkg::TMG_HOLD +: 2];
      last_off_r <= offchip;
    end
  end

  eda_tmr #(.W(4)) u_tmr (
    .clk    (clk),
    .arst_n (arst_n),
    .load   (ld),
    .val    (ld_val),
    .zero   (zero)
  );

  always_comb begin
    state_nxt = state_r;
    ld        = 1'b0;
    ld_val    = 4'h0;
    case (state_r)
      S_IDLE: begin
        if (go) begin
          state_nxt = offchip ? S_START : S_RAM; // RL11 RL25
        end
      end
      S_RAM:   state_nxt = S_RAMRD;
      S_RAMRD: state_nxt = S_IDLE;
      S_START, S_ALEL: begin
        if (state_r == S_START && mux_r) begin
          state_nxt = S_ALEH; // RL18
          ld        = 1'b1;
          ld_val    = {2'h0, alew_r}; // RL16
        end else if (zero || state_r == S_START) begin
          ld = 1'b1;
          if (setup_r != 2'h0) begin
            state_nxt = S_SETUP;
            ld_val    = {2'h0, setup_r - 2'h1};
          end else begin
            state_nxt = S_STRB;
            ld_val    = strb_r;
          end
        end
      end
      S_ALEH: begin
        if (zero) begin
          state_nxt = S_ALEL; // RL18
          ld        = 1'b1;
          ld_val    = {2'h0, alew_r}; // RL16
        end
      end
      S_SETUP: begin
        if (zero) begin
          state_nxt = S_STRB;
          ld        = 1'b1;
          ld_val    = strb_r;
        end
      end
      S_STRB: begin
        if (zero) begin
          ld = 1'b1;
          if (hold_r != 2'h0) begin
            state_nxt = S_HOLD;
            ld_val    = {2'h0, hold_r - 2'h1};
          end else begin
            state_nxt = S_FIN;
            ld_val    = eda_pkg::FIN_LD; // RL24
          end
        end
      end
      S_HOLD: begin
        if (zero) begin
          state_nxt = S_FIN;
          ld        = 1'b1;
          ld_val    = eda_pkg::FIN_LD; // RL24
        end
      end
      S_FIN: begin
        if (zero) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // pin image of the current state; only output enables and levels,
  // push-pull or open-drain stays with the port output mode logic (RL8)
  always_comb begin
    pins_c = eda_pkg::PINS_IDLE;
    if (state_r >= S_START) begin
      pins_c.ctl_oe = 1'b1; // RL6
      pins_c.ah     = ea_r[15:8];
      pins_c.ah_oe  = drive_hi_r; // RL12 RL14 RL23
      if (!mux_r) begin
        pins_c.al    = ea_r[7:0];
        pins_c.al_oe = 1'b1;
      end else if (state_r <= S_ALEL) begin
        pins_c.d    = ea_r[7:0]; // RL17
        pins_c.d_oe = 1'b1;
      end
      if (dir_r && state_r >= S_SETUP && state_r <= S_HOLD) begin
        pins_c.d    = wdat_r; // RL19
        pins_c.d_oe = 1'b1;
      end
      pins_c.ale  = (state_r == S_ALEH); // RL17 RL18
      pins_c.rd_n = ~(state_r == S_STRB && !dir_r); // RL7
      pins_c.wr_n = ~(state_r == S_STRB && dir_r);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_pins_r <= eda_pkg::PINS_IDLE;
      hi_pins_r <= eda_pkg::PINS_IDLE;
    end else begin
      lo_pins_r <= grp_r ? eda_pkg::PINS_IDLE : pins_c; // RL4 RL6
      hi_pins_r <= grp_r ? pins_c : eda_pkg::PINS_IDLE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_s1_r <= 8'h00;
      lo_s2_r <= 8'h00;
      hi_s1_r <= 8'h00;
      hi_s2_r <= 8'h00;
    end else begin
      lo_s1_r <= lo_data_i;
      lo_s2_r <= lo_s1_r;
      hi_s1_r <= hi_data_i;
      hi_s2_r <= hi_s1_r;
    end
  end

  assign din = grp_r ? hi_s2_r : lo_s2_r;

  // read data sampled two cycles after the last strobe state, which covers
  // the synchroniser lag only; the pin register adds one cycle more
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      samp_r <= 2'h0;
      rdat_r <= 8'h00;
    end else begin
      samp_r <= {samp_r[0], state_r == S_STRB && zero && !dir_r};
      if (samp_r[1]) begin
        rdat_r <= din;
      end else if (state_r == S_RAMRD && !dir_r) begin
        rdat_r <= ram_rdata;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ram_en_r    <= 1'b0;
      ram_we_r    <= 1'b0;
      ram_addr_r  <= 12'h000;
      ram_wdata_r <= 8'h00;
    end else begin
      ram_en_r    <= go & ~offchip; // RL25
      ram_we_r    <= go & ~offchip & pwdata[eda_pkg::CMD_DIR];
      ram_addr_r  <= ea[eda_pkg::RAM_AW-1:0]; // RL22
      ram_wdata_r <= pwdata[eda_pkg::CMD_WD +: 8];
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign ram_en    = ram_en_r;
  assign ram_we    = ram_we_r;
  assign ram_addr  = ram_addr_r;
  assign ram_wdata = ram_wdata_r;
  assign lo_pins   = lo_pins_r;
  assign hi_pins   = hi_pins_r;

  // checking helpers
  logic [5:0] mv_cnt_r;
  logic [5:0] mv_exp;
  logic [2:0] ale_cnt_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mv_cnt_r  <= 6'h00;
      ale_cnt_r <= 3'h0;
    end else begin
      mv_cnt_r  <= (state_r >= S_START) ? mv_cnt_r + 6'h01 : 6'h00;
      ale_cnt_r <= pins_c.ale ? ale_cnt_r + 3'h1 : 3'h0;
    end
  end
  assign mv_exp = eda_pkg::FIXED_CYC + {4'h0, setup_r} + {2'h0, strb_r}
                + 6'h01 + {4'h0, hold_r}
                + (mux_r ? {3'h0, alew_r, 1'b0} + 6'h02 : 6'h00);

  property p_move_len;
    @(posedge clk) disable iff (!arst_n)
      (state_r == S_FIN && zero) |-> (mv_cnt_r + 6'h01 == mv_exp);
  endproperty
  a_move_len: assert property (p_move_len) // RL24
    else $error("off-chip move length wrong");

  property p_ale_width;
    @(posedge clk) disable iff (!arst_n)
      $fell(pins_c.ale) |-> (ale_cnt_r == {1'b0, alew_r} + 3'h1);
  endproperty
  a_ale_width: assert property (p_ale_width) // RL16
    else $error("latch strobe high width wrong");

  property p_claim_only_move;
    @(posedge clk) disable iff (!arst_n)
      (lo_pins.ctl_oe | hi_pins.ctl_oe) |-> $past(state_r >= S_START);
  endproperty
  a_claim_only_move: assert property (p_claim_only_move) // RL6
    else $error("pins claimed outside off-chip move");

  property p_onchip_quiet;
    @(posedge clk) disable iff (!arst_n)
      (state_r == S_RAM) |=> !(lo_pins.ctl_oe | hi_pins.ctl_oe)
                             ##1 !(lo_pins.ctl_oe | hi_pins.ctl_oe);
  endproperty
  a_onchip_quiet: assert property (p_onchip_quiet) // RL25
    else $error("on-chip access touched pins");

  property p_read_no_drive;
    @(posedge clk) disable iff (!arst_n)
      (!lo_pins.rd_n && lo_pins.ctl_oe) |-> !lo_pins.d_oe;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive) // RL7
    else $error("data driven during read");

  property p_mode_int;
    @(posedge clk) disable iff (!arst_n)
      (go && cfg_r[eda_pkg::CFG_MODE +: 2] == eda_pkg::MODE_INT)
        |=> state_r == S_RAM ##1 state_r == S_RAMRD;
  endproperty
  a_mode_int: assert property (p_mode_int) // RL11
    else $error("internal mode went off-chip");

  property p_mode_ext;
    @(posedge clk) disable iff (!arst_n)
      (go && cfg_r[eda_pkg::CFG_MODE +: 2] == eda_pkg::MODE_EXT)
        |=> state_r == S_START;
  endproperty
  a_mode_ext: assert property (p_mode_ext) // RL15
    else $error("external mode stayed on-chip");

  property p_ram_wrap;
    @(posedge clk) disable iff (!arst_n)
      ram_en |-> ram_addr == ea_r[11:0];
  endproperty
  a_ram_wrap: assert property (p_ram_wrap) // RL22
    else $error("on-chip address not wrapped");

  property p_mux_phase;
    @(posedge clk) disable iff (!arst_n)
      (lo_pins.ale && lo_pins.ctl_oe) |-> lo_pins.d_oe
        && lo_pins.d == ea_r[7:0] && lo_pins.rd_n && lo_pins.wr_n;
  endproperty
  a_mux_phase: assert property (p_mux_phase) // RL18
    else $error("address phase wrong");
endmodule

//--- eda_mem_model.sv
`timescale 1ns/1ps
module eda_mem_model #(
  parameter int DLY = 0
) (
  input  wire logic          clk,
  input  eda_pkg::eda_pins_s pins,
  output logic [7:0]         dout
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat;
  logic [7:0]  last = 8'h00;
  logic [15:0] a;
  int          cnt = 0;
  // undriven upper lines sit at the parked port latch level
  assign a = {pins.ah_oe ? pins.ah : 8'hFF,
              pins.al_oe ? pins.al : lat};
  // released bus shows the inverse of the last byte, not a held value
  assign dout = (!pins.rd_n && cnt >= DLY) ? mem[a] : ~last;
  always @(posedge clk) begin
    if (pins.ale) lat <= pins.d;
    cnt <= pins.rd_n ? 0 : cnt + 1;
    if (!pins.rd_n) last <= mem[a];
    if (!pins.wr_n && pins.d_oe) mem[a] <= pins.d;
  end
endmodule

//--- test_external_data_memory_interface.sv
`timescale 1ns/1ps
module test_external_data_memory_interface;
  typedef struct packed {
    logic [5:0]  cfg;
    logic [7:0]  pg;
    logic [15:0] dp;
    logic [15:0] ix;
    logic [1:0]  sw;
    logic        off;
    logic [15:0] ea;
  } eda_row_s;
  localparam eda_row_s ROWS [11] = '{
    '{6'h10, 8'h00, 16'h1234, 16'h0000, 2'b01, 1'b0, 16'h0234},
    '{6'h10, 8'h2F, 16'h0000, 16'h0056, 2'b00, 1'b0, 16'h0F56},
    '{6'h14, 8'h00, 16'h0ABC, 16'h0000, 2'b01, 1'b0, 16'h0ABC},
    '{6'h14, 8'h00, 16'h8001, 16'h0000, 2'b01, 1'b1, 16'h8001},
    '{6'h14, 8'h40, 16'h0000, 16'h7700, 2'b10, 1'b1, 16'hFF77},
    '{6'h38, 8'h9A, 16'h0000, 16'h0011, 2'b00, 1'b1, 16'h9A11},
    '{6'h2C, 8'h00, 16'h0000, 16'h2200, 2'b10, 1'b1, 16'hFF22},
    '{6'h0F, 8'h00, 16'h0010, 16'h0000, 2'b01, 1'b1, 16'h0010},
    '{6'h09, 8'h00, 16'h1000, 16'h0000, 2'b01, 1'b1, 16'h1000},
    '{6'h18, 8'h0F, 16'h0000, 16'h00FF, 2'b00, 1'b0, 16'h0FFF},
    '{6'h10, 8'h00, 16'h2005, 16'h0000, 2'b01, 1'b0, 16'h0005}};
  logic               clk = 1'b0;
  logic               arst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr, ram_addr;
  logic [31:0]        pwdata, prdata, rd;
  logic               ram_en, ram_we, err;
  logic [7:0]         ram_wdata, ram_rdata, lo_di, hi_di, lo_md, hi_md;
  logic [7:0]         ram [0:4095];
  eda_pkg::eda_pins_s lo_pins, hi_pins;
  int                 mismatches = 0;
  int                 num_checks = 0;
  int                 lo_cl = 0;
  int                 hi_cl = 0;
  int                 ale_n = 0;

  always #5 clk = ~clk;
  assign lo_di = lo_pins.d_oe ? lo_pins.d : lo_md;
  assign hi_di = hi_pins.d_oe ? hi_pins.d : hi_md;

  eda_ctrl uut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ram_en(ram_en),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .lo_data_i(lo_di), .hi_data_i(hi_di),
    .lo_pins(lo_pins), .hi_pins(hi_pins));
  eda_mem_model #(.DLY(1)) m_lo (.clk(clk), .pins(lo_pins), .dout(lo_md));
  eda_mem_model #(.DLY(0)) m_hi (.clk(clk), .pins(hi_pins), .dout(hi_md));

  // on-chip ram answers the cycle after the request
  always @(posedge clk) begin
    if (ram_en === 1'b1) begin
      if (ram_we) ram[ram_addr] <= ram_wdata;
      ram_rdata <= ram[ram_addr];
    end
    if (lo_pins.ctl_oe === 1'b1) lo_cl++;
    if (hi_pins.ctl_oe === 1'b1) hi_cl++;
    if (lo_pins.ale === 1'b1) ale_n++;
    if (!lo_pins.rd_n && lo_pins.d_oe || !hi_pins.rd_n && hi_pins.d_oe) begin
      mismatches++;
      $display("ERROR read_drive exp 0 got 1");
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic move(input logic [15:0] cmd);
    int n;
    apb(1'b1, eda_pkg::IDX_CMD, 32'(cmd));
    n = 0;
    do begin
      apb(1'b0, eda_pkg::IDX_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    if (n == 200) mismatches++;
  endtask

  task automatic setup(input logic [5:0] cfg, input logic [7:0] pg,
                       input logic [15:0] dp, input logic [15:0] ix,
                       input logic [7:0] tm);
    apb(1'b1, eda_pkg::IDX_CFG, 32'(cfg));
    apb(1'b1, eda_pkg::IDX_TMG, 32'(tm));
    apb(1'b1, eda_pkg::IDX_PAGE, 32'(pg));
    apb(1'b1, eda_pkg::IDX_DATA_POINTER, 32'(dp));
    apb(1'b1, eda_pkg::IDX_INDEX, 32'(ix));
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #500000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    eda_row_s   r;
    logic [7:0] wd;
    int         lc, hc, base;
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ram_rdata = 8'h00;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      r = ROWS[i];
      wd = 8'hA0 + 8'(i);
      setup(r.cfg, r.pg, r.dp, r.ix, 8'h08);
      lc = lo_cl;
      hc = hi_cl;
      move({wd, 5'h0, r.sw, 1'b1});
      chk("offchip", 32'(r.off), 32'(rd[1]));
      if (r.off) begin
        chk("ext_mem", 32'(wd),
            32'(r.cfg[5] ? m_hi.mem[r.ea] : m_lo.mem[r.ea]));
      end else begin
        chk("ram", 32'(wd), 32'(ram[r.ea[11:0]]));
      end
      chk("lo_claim", 32'(r.off & ~r.cfg[5]), 32'(lo_cl != lc));
      chk("hi_claim", 32'(r.off & r.cfg[5]), 32'(hi_cl != hc));
      move({8'h00, 5'h0, r.sw, 1'b0});
      chk("rd_data", 32'(wd), 32'(rd[15:8]));
      chk("released", 32'h1, 32'(lo_pins === eda_pkg::PINS_IDLE &&
                                 hi_pins === eda_pkg::PINS_IDLE));
    end
    setup(6'h1C, 8'h00, 16'h0000, 16'h0000, 8'h00);
    lc = lo_cl;
    move(16'h0001);
    base = lo_cl - lc;
    setup(6'h1C, 8'h00, 16'h0000, 16'h0000, 8'hFF);
    lc = lo_cl;
    move(16'h0001);
    chk("slow_move", 32'(base + 21), 32'(lo_cl - lc));
    for (int c = 0; c < 4; c++) begin
      setup(6'h0C + 6'(c), 8'h00, 16'h0000, 16'h0000, 8'h00);
      lc = lo_cl;
      ale_n = 0;
      move(16'h0001);
      chk("ale_high", 32'(c + 1), 32'(ale_n));
      chk("mux_move", 32'(base + 2 * (c + 1)), 32'(lo_cl - lc));
    end
    apb(1'b1, eda_pkg::IDX_DPL, 32'h34);
    apb(1'b1, eda_pkg::IDX_DPH, 32'h12);
    apb(1'b0, eda_pkg::IDX_DATA_POINTER, 32'h0);
    chk("data_pointer", 32'h1234, rd);
    apb(1'b1, eda_pkg::IDX_CFG, 32'hFF);
    apb(1'b0, eda_pkg::IDX_CFG, 32'h0);
    chk("cfg_top", 32'h3F, rd);
    apb(1'b0, 8'hFF, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    chk("pins_rst", 32'h1, 32'(lo_pins === eda_pkg::PINS_IDLE));
    apb(1'b0, eda_pkg::IDX_PAGE, 32'h0);
    chk("page_rst", 32'h0, rd);
    apb(1'b0, eda_pkg::IDX_CFG, 32'h0);
    chk("cfg_rst", 32'h3, rd);
    apb(1'b0, eda_pkg::IDX_TMG, 32'h0);
    chk("tmg_rst", 32'hFF, rd);
    report_and_stop();
  end
endmodule
